// file: pkg/tsb_defines.svh
// constant names for the time stamp capture buffers
// assumes inclusion by bare name from package and modules
`ifndef TSB_DEFINES_SVH
`define TSB_DEFINES_SVH
`define REC_W 16
`define NBUF 3
`define NSRC 8
`define PAGES 16
`define CAP_FIRST 6'h0a
`define CAP_SECOND 6'h0c
`define CAP_THIRD 6'h0a
`define ADDR_CFG 8'h42
`define ADDR_TRG 8'h43
`define CFG_SEL_BIT 0
`define CFG_CNTCLR_BIT 4
`define CFG_BUFCLR_LSB 5
`define LAST_BIT 4'hf
`define EMPTY_RST 3'b111
`define SRC_CMD 3'h0
`define SRC_PIN0 3'h1
`define SRC_PIN1 3'h2
`endif

// file: pkg/tsb_pkg.sv
// types shared by the capture buffer modules
// assumes tsb_defines.svh is on the include path
`include "tsb_defines.svh"
package tsb_pkg;
	typedef logic [`REC_W-1:0] rec_t;
	typedef logic [`NBUF-1:0][5:0] ptr_arr_t;
	typedef logic [`NBUF-1:0][3:0] thr_arr_t;
	typedef logic [7:0] byte_t;
endpackage

// file: pkg/cmd_link_if.sv
// command port signals between serial decoder and buffer core
// assumes both ends share clk
interface cmd_link_if;
	logic fire; // one-cycle command trigger pulse
	tsb_pkg::byte_t commandConfig; // command config byte
	tsb_pkg::byte_t triggerByte; // trigger register contents
	logic trgDone; // core finished the trigger
	modport port (output fire, output commandConfig, output triggerByte, input trgDone);
	modport core (input fire, input commandConfig, input triggerByte, output trgDone);
endinterface

// file: logic/two_entry_buffer.sv
// two-entry valid/ready buffer on the read data path
// assumes producer and consumer on clk
`include "tsb_defines.svh"
module two_entry_buffer
	import tsb_pkg::*;
(
	input wire logic clk, // clock
	input wire logic rst_n, // async reset, active low
	input wire logic inValid, // producer offers a word
	output logic inReady, // room for a word
	input tsb_pkg::rec_t inData, // word in
	output logic outValid, // word available
	input wire logic outReady, // consumer takes the word
	output tsb_pkg::rec_t outData // oldest word
);
	typedef struct packed {
		logic [1:0][`REC_W-1:0] slot;
		logic [1:0] count;
	} fifo_state_t;
	fifo_state_t q, d;
	logic push, pop;

	////////////////////////////////////////////////////////////////
	// honest full and empty from the count
	assign inReady = (q.count != 2'h2);
	assign outValid = (q.count != 2'h0);
	assign outData = q.slot[0];
	assign push = inValid & inReady;
	assign pop = outValid & outReady;

	// shift out of slot 0, append behind the remaining word
	always_comb
	begin
		d = q;
		if (pop)
		begin
			d.slot[0] = q.slot[1];
			d.count = q.count - 2'h1;
		end
		if (push)
			d.slot[d.count[0]] = inData;
		if (push)
			d.count = d.count + 2'h1;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end
endmodule

// file: logic/serial_cmd_port.sv
// three-wire write decoder for command config and trigger registers
// assumes the serial clock and select arrive unsynchronised from the host
`include "tsb_defines.svh"
module serial_cmd_port
	import tsb_pkg::*;
(
	input wire logic clk, // clock
	input wire logic rst_n, // async reset, active low
	input wire logic serClk, // host serial clock
	input wire logic serSel_n, // host select, active low
	input wire logic serData, // host serial data, msb first
	cmd_link_if.port link // command signals to the core
);
	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
		logic clkPrev;
		logic [3:0] cnt;
		logic [14:0] shift;
		byte_t cfg;
		byte_t trg;
		logic fire;
	} port_state_t;
	port_state_t q, d;
	logic rise;
	byte_t addr, data;

	////////////////////////////////////////////////////////////////
	assign rise = q.s2[0] & ~q.clkPrev;
	assign addr = q.shift[14:7];
	assign data = {q.shift[6:0], q.s2[2]};
	assign link.fire = q.fire;
	assign link.commandConfig = q.cfg;
	assign link.triggerByte = q.trg;

	// 16-bit frame: address byte then data byte
	always_comb
	begin
		d = q;
		d.s1 = {serData, serSel_n, serClk};
		d.s2 = q.s1;
		d.clkPrev = q.s2[0];
		d.fire = 1'b0;
		if (link.trgDone)
			d.trg = 8'h00;
		if (q.s2[1])
			d.cnt = 4'h0;
		else if (rise)
		begin
			d.shift = {q.shift[13:0], q.s2[2]};
			d.cnt = q.cnt + 4'h1;
			if (q.cnt == `LAST_BIT)
			begin
				if (addr == `ADDR_CFG)
					d.cfg = data;
				// fires on the edge carrying the data lsb
				if (addr == `ADDR_TRG)
				begin
					d.trg = data;
					d.fire = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end
endmodule

// file: logic/ts_capture_buffers.sv
// time stamp capture buffers: arbitration, three record buffers,
// status flags, command trigger handling and read path
// assumes recordIn holds a stable snapshot of counters and flags
// assumes event inputs are filtered levels from other clock domains
// assumes the host waits for the trigger byte to read zero between triggers
// Function
// - fifo mode writes capture at ring head plus the fill pointer, then increments it
// - fifo mode fill pointer equals count of unread records
// - threshold reached raises buffer irq flag; irq pin only when enabled
// - fifo read returns oldest record and decrements fill pointer
// - direct mode routes capture by source; trigger counter picks page
// - direct mode counter increments per write; threshold raises irq flag
// - filling without read sets full-now and full-history flags
// - overwrite off drops captures while buffer full
// - direct mode, overwrite off, counter holds at full value
// - overwrite on replaces oldest; direct counter wraps and continues
// - any overwrite sets the buffer overflow flag
// - fifo mode: reading out every record sets the empty flag
// - writing a record clears the empty flag
// - full-now clears when a read frees space
// - full-history stays until host writes zero to it
// - host sets select bit then writes trigger byte; device captures
// - trigger byte returns to zero after command trigger; host polls
// - command trigger capture always goes into first buffer
// - three-wire variant fires on clock edge of trigger data lsb
// - command trigger with counter clear resets pin event counters
// - command trigger with buffer clear zeroes full, empty, pointer, overflow
// - four enables gate captures by internal events
// - capacities ten, twelve, ten; pins to own buffers, internals third
// - overwrite enable one selects overwrite, zero inhibits
// - threshold zero suppresses the buffer interrupt
`include "tsb_defines.svh"
module ts_capture_buffers
	import tsb_pkg::*;
(
	input wire logic clk, // 20 MHz clock
	input wire logic rst_n, // async reset, active low
	input wire logic serClk, // host serial clock
	input wire logic serSel_n, // host serial select, active low
	input wire logic serData, // host serial data
	input wire logic directMode, // 1 direct mode, 0 fifo mode
	input wire logic [2:0] overwriteEnable, // per buffer overwrite enable
	input tsb_pkg::thr_arr_t irqThresholdLow, // low nibble of thresholds
	input wire logic [1:0] irqThresholdHigh, // first buffer threshold bits 5:4
	input wire logic irqEnable, // interrupt pin enable
	input wire logic [2:0] pinCaptureEn, // capture enables, event pins
	input wire logic [3:0] internalCaptureEnables, // capture enables, internal
	input wire logic [2:0] eventPin, // filtered event pins, async
	input wire logic [3:0] internalEvent, // internal detect events, async
	input tsb_pkg::rec_t recordIn, // snapshot of counters and flags
	input wire logic [2:0] irqFlagClear, // host writes zero to irq flag
	input wire logic [2:0] fullHistoryClear, // host writes zero to history
	input wire logic readReq, // host read request
	output logic readAccept, // read request taken
	input wire logic [1:0] readBuf, // direct mode buffer select
	input wire logic [3:0] readPageSelect, // direct mode page select
	output logic readValid, // record word available
	input wire logic readReady, // host takes the word
	output tsb_pkg::rec_t readData, // record word
	output tsb_pkg::ptr_arr_t fillPointer, // pointers or trigger counters
	output logic [2:0] fullNowFlag, // buffer currently full
	output logic [2:0] fullHistoryFlag, // buffer has been full
	output logic [2:0] overflowFlag, // data overwritten
	output logic [2:0] emptyFlag, // buffer empty
	output logic [2:0] bufferIrqFlag, // threshold reached
	output logic irq_n, // interrupt output, active low
	output logic counterClear, // clear pin event counters pulse
	output tsb_pkg::byte_t triggerByte // trigger register readback
);
	// core state apart from record storage, registered in one place
	typedef struct packed {
		logic [6:0] sync1;
		logic [6:0] sync2;
		logic [6:0] prev;
		logic [`NSRC-1:0] pend;
		ptr_arr_t ptr;
		thr_arr_t head;
		logic [2:0] full;
		logic [2:0] hist;
		logic [2:0] ovw;
		logic [2:0] empty;
		logic [2:0] irqf;
		logic cntClr;
	} core_state_t;
	core_state_t q, d;
	rec_t mem [0:`NBUF-1][0:`PAGES-1];
	cmd_link_if link ();
	logic [6:0] edges;
	logic [`NSRC-1:0] newEv;
	logic [2:0] pick;
	logic anyPend, wrEn, readTake, fifoInReady;
	logic [1:0] wrBuf;
	logic [3:0] wrPage;
	logic [5:0] thr [0:`NBUF-1];
	rec_t fifoIn;
	logic [`NBUF-1:0] irqReq;

	////////////////////////////////////////////////////////////////
	// record capacity of a buffer
	function automatic logic [5:0] capOf(input int b);
		if (b == 0)
			return `CAP_FIRST;
		else if (b == 1)
			return `CAP_SECOND;
		return `CAP_THIRD;
	endfunction

	// destination buffer of a source
	function automatic logic [1:0] routeOf(input logic [2:0] src, input logic dir);
		if (!dir || src == `SRC_CMD || src == `SRC_PIN0)
			return 2'h0;
		else if (src == `SRC_PIN1)
			return 2'h1;
		return 2'h2;
	endfunction

	// ring index step with wrap at capacity
	function automatic logic [3:0] ringAdd(input logic [3:0] a, input logic [5:0] n,
		input int b);
		logic [5:0] s;
		s = {2'h0, a} + n;
		if (s >= capOf(b))
			s = s - capOf(b);
		return s[3:0];
	endfunction

	////////////////////////////////////////////////////////////////
	// host write port: config and trigger registers
	serial_cmd_port cmdPort (
		.clk(clk),
		.rst_n(rst_n),
		.serClk(serClk),
		.serSel_n(serSel_n),
		.serData(serData),
		.link(link.port)
	);

	// read words pass a two-entry buffer so a stalled host loses none
	two_entry_buffer readBuffer (
		.clk(clk),
		.rst_n(rst_n),
		.inValid(readTake),
		.inReady(fifoInReady),
		.inData(fifoIn),
		.outValid(readValid),
		.outReady(readReady),
		.outData(readData)
	);

	////////////////////////////////////////////////////////////////
	// thresholds widened to pointer width; only the first buffer has bits 5:4
	genvar g;
	generate
		for (g = 0; g < `NBUF; g++)
		begin : gThr
			if (g == 0)
			begin : gWide
				assign thr[g] = {irqThresholdHigh, irqThresholdLow[g]};
			end
			else
			begin : gNarrow
				assign thr[g] = {2'h0, irqThresholdLow[g]};
			end
		end
	endgenerate

	// edges of synchronised events, gated by capture enables
	assign edges = q.sync2 & ~q.prev;
	assign newEv[0] = link.fire & link.commandConfig[`CFG_SEL_BIT];
	assign newEv[3:1] = edges[2:0] & pinCaptureEn;
	assign newEv[7:4] = edges[6:3] & internalCaptureEnables;

	// fixed priority pick, command first then pins then internals
	always_comb
	begin
		pick = 3'h0;
		anyPend = 1'b0;
		for (int i = `NSRC - 1; i >= 0; i--)
		begin
			if (q.pend[i])
			begin
				pick = 3'(i);
				anyPend = 1'b1;
			end
		end
	end

	// fifo reads only with records present; direct reads by page
	assign readAccept = readReq & fifoInReady;
	assign readTake = readAccept & (directMode | (q.ptr[0] != 6'h00));
	assign fifoIn = directMode ? mem[readBuf][readPageSelect] : mem[0][q.head[0]];

	// buffer that the served source writes into
	assign wrBuf = routeOf(pick, directMode);

	// trigger byte cleared once the command is done
	assign link.trgDone = (anyPend & (pick == `SRC_CMD))
		| (link.fire & ~link.commandConfig[`CFG_SEL_BIT]);

	////////////////////////////////////////////////////////////////
	// next state: sync, pending, command clears, reads, writes
	always_comb
	begin
		logic [5:0] p;
		logic [3:0] h;
		p = 6'h00;
		h = 4'h0;
		d = q;
		// no write unless a capture is served below
		wrEn = 1'b0;
		wrPage = 4'h0;
		// event inputs: two flip-flops, then the previous value for edges
		d.sync1 = {internalEvent, eventPin};
		d.sync2 = q.sync1;
		d.prev = q.sync2;
		// counter clear follows the command fire for one cycle
		d.cntClr = link.fire & link.commandConfig[`CFG_CNTCLR_BIT];
		// pending events; the served source stays set only if it fired again
		d.pend = q.pend | newEv;
		if (anyPend)
			d.pend[pick] = newEv[pick];
		for (int b = 0; b < `NBUF; b++)
		begin
			// working copies of pointer and ring head for this buffer
			p = q.ptr[b];
			h = q.head[b];
			// command clear of flags and pointer
			if (link.fire && link.commandConfig[`CFG_BUFCLR_LSB + b])
			begin
				p = 6'h00;
				h = 4'h0;
				d.full[b] = 1'b0;
				d.empty[b] = 1'b0;
				d.ovw[b] = 1'b0;
			end
			// fifo read of oldest record
			if (b == 0 && !directMode && readTake && p != 6'h00)
			begin
				h = ringAdd(h, 6'h01, b);
				p = p - 6'h01;
				d.full[b] = 1'b0;
				if (p == 6'h00)
					d.empty[b] = 1'b1;
			end
			// host clears of irq and history, beaten by a new set
			if (irqFlagClear[b])
				d.irqf[b] = 1'b0;
			if (fullHistoryClear[b])
				d.hist[b] = 1'b0;
			// capture into this buffer
			if (anyPend && wrBuf == 2'(b))
			begin
				// room left: write behind the newest record
				if (p != capOf(b))
				begin
					wrEn = 1'b1;
					wrPage = directMode ? 4'(p + 6'h01) : ringAdd(h, p, b);
					p = p + 6'h01;
					d.empty[b] = 1'b0;
					if (p == capOf(b))
					begin
						d.full[b] = 1'b1;
						d.hist[b] = 1'b1;
					end
					if (p == thr[b])
						d.irqf[b] = 1'b1;
				end
				// full with overwrite on: the oldest record goes
				else if (overwriteEnable[b])
				begin
					wrEn = 1'b1;
					d.ovw[b] = 1'b1;
					d.empty[b] = 1'b0;
					if (directMode)
					begin
						// counter circulates: page one again
						p = 6'h01;
						wrPage = 4'h1;
						d.irqf[b] = (p == thr[b]);
					end
					else
					begin
						wrPage = h;
						h = ringAdd(h, 6'h01, b);
					end
				end
				// overwrite off: record dropped, counter holds
				else
					p = q.ptr[b];
			end
			// commit pointer and head
			d.ptr[b] = p;
			d.head[b] = h;
		end
	end

	////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q <= '0;
			q.empty <= `EMPTY_RST;
		end
		else
			q <= d;
	end

	// record storage, one write per cycle
	always_ff @(posedge clk)
	begin
		if (wrEn)
			mem[wrBuf][wrPage] <= recordIn;
	end

	////////////////////////////////////////////////////////////////
	// status outputs
	assign fillPointer = q.ptr;
	assign fullNowFlag = q.full;
	assign fullHistoryFlag = q.hist;
	assign overflowFlag = q.ovw;
	assign emptyFlag = q.empty;
	assign bufferIrqFlag = q.irqf;
	assign counterClear = q.cntClr;
	assign triggerByte = link.triggerByte;

	// per buffer request: flag set and threshold nonzero
	generate
		for (g = 0; g < `NBUF; g++)
		begin : gIrq
			assign irqReq[g] = q.irqf[g] & (thr[g] != 6'h00);
		end
	endgenerate

	// interrupt pin low while any request stands, only when enabled
	assign irq_n = ~(irqEnable & (|irqReq));
endmodule

// file: sim/ts_monitor.sv
// assertions on the capture buffer top ports
// assumes a bind onto ts_capture_buffers
`include "tsb_defines.svh"
module ts_monitor (
	input wire logic clk, // clock
	input wire logic rst_n, // async reset, active low
	input wire logic irqEnable, // irq pin enable
	input wire logic readReady, // host takes word
	input wire logic readValid, // word available
	input tsb_pkg::rec_t readData, // record word
	input tsb_pkg::ptr_arr_t fillPointer, // pointers
	input wire logic [2:0] fullNowFlag, // full now
	input wire logic [2:0] fullHistoryFlag, // full history
	input wire logic [2:0] fullHistoryClear, // history clear
	input wire logic [2:0] emptyFlag, // empty
	input wire logic [2:0] overflowFlag, // overwrite happened
	input wire logic [2:0] bufferIrqFlag, // irq flags
	input wire logic irq_n, // irq pin
	input wire logic counterClear // counter clear pulse
);
	import tsb_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////
	// flag and pin relations
	property p_irqPin;
		(bufferIrqFlag == 3'b000 || (!irqEnable && !$past(irqEnable))) |-> irq_n;
	endproperty
	property p_fullSetsHistory;
		$rose(fullNowFlag[0]) |-> ##[0:1] fullHistoryFlag[0];
	endproperty
	property p_historySticky;
		$fell(fullHistoryFlag[0]) |-> $past(fullHistoryClear[0]);
	endproperty
	property p_capBound;
		fillPointer[0] <= `CAP_FIRST && fillPointer[1] <= `CAP_SECOND
			&& fillPointer[2] <= `CAP_THIRD;
	endproperty
	property p_fullAtCap;
		$rose(fullNowFlag[1]) |-> fillPointer[1] == `CAP_SECOND;
	endproperty
	property p_emptyWhenFilled;
		fillPointer[0] != 6'h00 |-> !emptyFlag[0];
	endproperty
	property p_readHold;
		readValid && !readReady |=> readValid && $stable(readData);
	endproperty
	property p_clearPulse;
		counterClear |=> !counterClear;
	endproperty
	////////////////////////////////////////
	// checks and covers
	a_irqPin: assert property (p_irqPin) else $error("irq pin low while idle or masked");
	a_fullSetsHistory: assert property (p_fullSetsHistory) else $error("history not set");
	a_historySticky: assert property (p_historySticky) else $error("history fell alone");
	a_capBound: assert property (p_capBound) else $error("pointer beyond capacity");
	a_fullAtCap: assert property (p_fullAtCap) else $error("full at wrong count");
	a_emptyWhenFilled: assert property (p_emptyWhenFilled) else $error("empty while filled");
	a_readHold: assert property (p_readHold) else $error("read word dropped in stall");
	a_clearPulse: assert property (p_clearPulse) else $error("counter clear too long");
	c_full: cover property (fullNowFlag[0]);
	c_overflow: cover property (overflowFlag[1]);
	c_read: cover property (readValid && readReady);
endmodule

bind ts_capture_buffers ts_monitor mon (.clk, .rst_n, .irqEnable, .readReady, .readValid,
	.readData, .fillPointer, .fullNowFlag, .fullHistoryFlag, .fullHistoryClear, .emptyFlag,
	.overflowFlag, .bufferIrqFlag, .irq_n, .counterClear);

// file: sim/host_serial_model.sv
// host side of the three-wire write port
// assumes the bench calls send between frames only
module host_serial_model (
	output logic serClk, // serial clock, idle low
	output logic serSel_n, // select, active low
	output logic serData // serial data
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle link
	initial
	begin
		serClk = 1'b0;
		serSel_n = 1'b1;
		serData = 1'b1;
	end
	// address byte then data byte, msb first, 400 ns bit time
	task automatic send(input tsb_pkg::byte_t a, input tsb_pkg::byte_t d);
		logic [15:0] w;
		int i;
		w = {a, d};
		serSel_n = 1'b0;
		for (i = 15; i >= 0; i--)
		begin
			serData = w[i];
			#200 serClk = 1'b1;
			#200 serClk = 1'b0;
		end
		#200 serSel_n = 1'b1;
		serData = ~serData; // released line shows no stale bit
		#400; // deselected gap before any next frame
	endtask
endmodule

// file: sim/testbench.sv
// self-checking bench for the time stamp capture buffers
// assumes the host model and the monitor bind compile alongside
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import tsb_pkg::*;
	logic clk, rst_n, directMode, irqEnable, readReq, readReady, serClk, serSel_n, serData;
	logic [2:0] overwriteEnable, pinCaptureEn, eventPin, irqFlagClear, fullHistoryClear;
	logic [3:0] internalCaptureEnables, internalEvent, readPageSelect;
	logic [1:0] irqThresholdHigh, readBuf;
	logic [2:0] fullNowFlag, fullHistoryFlag, overflowFlag, emptyFlag, bufferIrqFlag;
	logic readAccept, readValid, irq_n, counterClear;
	thr_arr_t irqThresholdLow;
	rec_t recordIn, readData;
	ptr_arr_t fillPointer;
	byte_t triggerByte;
	int n_mismatch = 0;
	int total_checks = 0;
	int nClr = 0;
	int nTrg = 0;
	////////////////////////////////////////
	ts_capture_buffers dut (.clk, .rst_n, .serClk, .serSel_n, .serData, .directMode,
		.overwriteEnable, .irqThresholdLow, .irqThresholdHigh, .irqEnable, .pinCaptureEn,
		.internalCaptureEnables, .eventPin, .internalEvent, .recordIn, .irqFlagClear,
		.fullHistoryClear, .readReq, .readAccept, .readBuf, .readPageSelect, .readValid,
		.readReady, .readData, .fillPointer, .fullNowFlag, .fullHistoryFlag, .overflowFlag,
		.emptyFlag, .bufferIrqFlag, .irq_n, .counterClear, .triggerByte);
	host_serial_model host (.serClk, .serSel_n, .serData);
	// clock, 50 ns period
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// count counter clear pulses and cycles with the trigger byte written
	always @(posedge clk)
	begin
		if (counterClear === 1'b1)
			nClr++;
		if (triggerByte === 8'h5a)
			nTrg++;
	end
	////////////////////////////////////////
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e)
		begin
			$display("unexpected %s expected %h seen %h", n, e, g);
			n_mismatch++;
		end
	endtask
	// one event edge with a fresh snapshot
	task automatic hit(input logic [2:0] p, input logic [3:0] q);
		@(posedge clk);
		recordIn <= recordIn + 16'h0001;
		eventPin <= p;
		internalEvent <= q;
		repeat (3) @(posedge clk);
		eventPin <= 3'b000;
		internalEvent <= 4'h0;
		repeat (8) @(posedge clk);
	endtask
	// one read with a two-cycle stall on the taking side
	task automatic rd(input rec_t e);
		int i;
		@(posedge clk);
		readReq <= 1'b1;
		for (i = 0; i < 8 && readAccept !== 1'b1; i++)
			@(negedge clk);
		chk("readAccept", 16'h0001, readAccept);
		@(posedge clk);
		readReq <= 1'b0;
		for (i = 0; i < 8 && readValid !== 1'b1; i++)
			@(negedge clk);
		repeat (2) @(negedge clk);
		chk("readValid", 16'h0001, readValid);
		chk("readData", e, readData);
		@(posedge clk);
		readReady <= 1'b1;
		@(posedge clk);
		readReady <= 1'b0;
	endtask
	// config byte, trigger byte, then poll for zero
	task automatic cmd(input byte_t cfg);
		int i, t0;
		t0 = nTrg;
		host.send(8'h42, cfg);
		host.send(8'h43, 8'h5a);
		for (i = 0; i < 200 && triggerByte !== 8'h00; i++)
			@(negedge clk);
		chk("triggerByte", 16'h0000, triggerByte);
		chk("triggerByte set", 16'h0001, (nTrg > t0) ? 16'h0001 : 16'h0000);
		repeat (4) @(posedge clk);
	endtask
	////////////////////////////////////////
	task automatic t_reset();
		chk("emptyFlag", 16'h0007, emptyFlag);
		chk("fillPointer", 16'h0000, {fillPointer[1], fillPointer[0]});
		chk("fullHistoryFlag", 16'h0000, fullHistoryFlag);
		chk("irq_n", 16'h0001, irq_n);
	endtask
	// fifo fill past capacity with overwrite off, then drain
	task automatic t_fifo();
		int k;
		@(posedge clk);
		recordIn <= 16'h1000;
		for (k = 1; k <= 11; k++)
		begin
			hit(3'b001, 4'h0);
			chk("fillPointer0", (k > 10) ? 10 : k, fillPointer[0]);
			if (k == 3)
				chk("irq_n", 16'h0000, irq_n);
		end
		chk("fullNowFlag", 16'h0001, fullNowFlag);
		chk("fullHistoryFlag", 16'h0001, fullHistoryFlag);
		irqEnable <= 1'b0;
		repeat (2) @(negedge clk);
		chk("irq_n masked", 16'h0001, irq_n);
		@(posedge clk);
		irqEnable <= 1'b1;
		for (k = 1; k <= 10; k++)
			rd(16'h1000 + k);
		chk("fillPointer0", 16'h0000, fillPointer[0]);
		chk("emptyFlag", 16'h0007, emptyFlag);
		chk("fullNowFlag", 16'h0000, fullNowFlag);
		chk("fullHistoryFlag", 16'h0001, fullHistoryFlag);
		@(posedge clk);
		fullHistoryClear <= 3'b001;
		irqFlagClear <= 3'b001;
		@(posedge clk);
		fullHistoryClear <= 3'b000;
		irqFlagClear <= 3'b000;
		repeat (2) @(negedge clk);
		chk("fullHistoryFlag", 16'h0000, fullHistoryFlag);
		chk("bufferIrqFlag", 16'h0000, bufferIrqFlag);
	endtask
	// fifo overwrite, then command clear of counters and flags
	task automatic t_ovw();
		int k, c0;
		@(posedge clk);
		overwriteEnable <= 3'b001;
		recordIn <= 16'h2000;
		for (k = 1; k <= 11; k++)
			hit(3'b001, 4'h0);
		chk("fillPointer0", 16'h000a, fillPointer[0]);
		chk("overflowFlag", 16'h0001, overflowFlag);
		rd(16'h2002);
		c0 = nClr;
		cmd(8'hf0);
		chk("fillPointer0", 16'h0000, fillPointer[0]);
		chk("cleared flags", 16'h0000, {overflowFlag, fullNowFlag, emptyFlag});
		chk("counterClear", 16'h0001, 16'(nClr - c0));
	endtask
	// direct mode routing, hold, wrap, internal enables, command capture
	task automatic t_direct();
		int k;
		@(posedge clk);
		directMode <= 1'b1;
		overwriteEnable <= 3'b000;
		for (k = 1; k <= 13; k++)
		begin
			hit(3'b010, 4'h0);
			if (k == 5)
				chk("bufferIrqFlag1", 16'h0001, bufferIrqFlag[1]);
		end
		chk("fillPointer1", 16'h000c, fillPointer[1]);
		chk("fillPointer0", 16'h0000, fillPointer[0]);
		chk("fullNowFlag", 16'h0002, fullNowFlag);
		overwriteEnable <= 3'b010;
		hit(3'b010, 4'h0);
		chk("fillPointer1", 16'h0001, fillPointer[1]);
		chk("overflowFlag", 16'h0002, overflowFlag);
		internalCaptureEnables <= 4'h0;
		hit(3'b000, 4'hf);
		chk("fillPointer2", 16'h0000, fillPointer[2]);
		internalCaptureEnables <= 4'hf;
		hit(3'b100, 4'hf);
		chk("fillPointer2", 16'h0005, fillPointer[2]);
		cmd(8'h01);
		chk("fillPointer0", 16'h0001, fillPointer[0]);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	////////////////////////////////////////
	// main sequence
	initial
	begin
		rst_n = 1'b0;
		directMode = 1'b0;
		irqEnable = 1'b1;
		readReq = 1'b0;
		readReady = 1'b0;
		overwriteEnable = 3'b000;
		pinCaptureEn = 3'b111;
		eventPin = 3'b000;
		irqFlagClear = 3'b000;
		fullHistoryClear = 3'b000;
		internalCaptureEnables = 4'hf;
		internalEvent = 4'h0;
		readPageSelect = 4'h0;
		readBuf = 2'b00;
		irqThresholdHigh = 2'b00;
		irqThresholdLow = 12'h053;
		recordIn = 16'h0000;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		t_reset();
		t_fifo();
		t_ovw();
		t_direct();
		end_of_test();
	end
	// hang guard, far beyond the expected run
	initial
	begin
		#2000000;
		n_mismatch++;
		end_of_test();
	end
endmodule
